// ---- logic/hpag_core.sv ----
// Host port address registers, pin takeover for I/O and the Avalon register slave
// Operation
// - Port disabled: every pin free for I/O
// - Port enabled: unused pins still configurable
// - I/O pins seen as data 0, control 1
// - Each pin has enable, direction, data
// - Address strobe enable resets to zero
// - Enable hands pin over, strobe forced high
// - Direction one drives pin, zero inputs
// - Output pin: data write drives, reads back
// - Input pin: writes ignored, reads pin level
// - No preload; output starts with last input
// - Two address registers, read and write use
// - Dual bit selects shared or separate registers
// - Shared mode: address write loads both
// - Shared mode: autoincrement advances both
// - Shared mode: address read returns read register
// - Dual mode: select bit picks addressed register
// - Select bit never steers memory addresses
// - Dual mode: increment only matching register
// - Increment only after the memory access
// - Code 11 leaves addresses unchanged
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`include "hpag_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module hpag_core #(
  parameter int NPINS = `HPAG_NUM_PINS
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Avalon-MM slave
  input  wire logic [4:0]         avAddress,
  input  wire logic               avRead,
  input  wire logic               avWrite,
  input  wire logic [3:0]         avByteenable,
  input  wire logic [31:0]        avWritedata,
  output logic [31:0]             avReaddata,
  output logic                    avWaitrequest,
  // Chip configuration
  input  wire logic               hostPortEnable,
  // Decoded host cycles from the strobe logic
  input  wire logic               cycStart,
  input  wire logic [1:0]         cycCntl,
  input  wire logic               cycRead,
  input  wire logic [31:0]        cycWdata,
  output logic [31:0]             cycRdata,
  // Memory-access logic
  input  wire logic               memRdDone,
  input  wire logic               memWrDone,
  output logic [31:0]             memReadAddr,
  output logic [31:0]             memWriteAddr,
  // Host function drive onto the data bus
  input  wire logic [15:0]        hostDataOut,
  input  wire logic               hostDataDrive,
  output logic [NPINS-1:0]        hostPinView,
  // Device pins
  input  wire logic [NPINS-1:0]   pinIn,
  output logic [NPINS-1:0]        pinOut,
  output logic [NPINS-1:0]        pinOeN
);

  // Byte-enable mask for register writes
  function automatic logic [31:0] beMask(input logic [3:0] be);
    beMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Access kind from the access control code
  function automatic hpag_pkg::hpag_acc_t accKind(input logic [1:0] c);
    case (c)
      2'h0:    accKind = hpag_pkg::ACC_CTRL;
      2'h1:    accKind = hpag_pkg::ACC_DATA_INC;
      2'h2:    accKind = hpag_pkg::ACC_ADDR;
      default: accKind = hpag_pkg::ACC_DATA;
    endcase
  endfunction

  logic [8:0]        ioEnR;
  logic [NPINS-1:0]  dirR;
  logic [NPINS-1:0]  datR;
  logic [31:0]       ctrlR;
  logic [31:0]       readAddrR;
  logic [31:0]       writeAddrR;
  logic              incRdPendR;
  logic              incWrPendR;
  logic              ackR;
  logic [NPINS-1:0]  pinMeta;
  logic [NPINS-1:0]  pinSync;
  logic [NPINS-1:0]  ioEnPin;
  logic [NPINS-1:0]  ioEnEff;
  logic [NPINS-1:0]  pinOut_nxt;
  logic [NPINS-1:0]  pinOeN_nxt;
  logic [31:0]       avMask;
  logic              avWrAcc;
  logic              dualMode;
  logic              addrSel;
  logic              hostAddrWr;
  logic              hostCtrlWr;
  logic              rdIncNow;
  logic              wrIncNow;
  hpag_pkg::hpag_acc_t cycKind;

  // Two-flop synchroniser; pins are asynchronous to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  // One wait state on every access keeps read data registered
  assign avWaitrequest = (avRead | avWrite) & ~ackR;
  assign avWrAcc       = avWrite & ackR;
  assign avMask        = beMask(avByteenable);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ackR <= 1'b0;
    end else begin
      ackR <= (avRead | avWrite) & ~ackR;
    end
  end

  // Readback; unmapped offsets read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avReaddata <= '0;
    end else if (avRead & ~ackR) begin
      if (avAddress == `HPAG_OFS_IO_ENABLE) begin
        avReaddata <= 32'(ioEnR);
      end else if (avAddress == `HPAG_OFS_PIN_DIR) begin
        avReaddata <= 32'(dirR);
      end else if (avAddress == `HPAG_OFS_PIN_DATA) begin
        avReaddata <= 32'(datR);
      end else if (avAddress == `HPAG_OFS_PORT_CTRL) begin
        avReaddata <= ctrlR;
      end else if (avAddress == `HPAG_OFS_READ_ADDR) begin
        avReaddata <= readAddrR;
      end else if (avAddress == `HPAG_OFS_WRITE_ADDR) begin
        avReaddata <= writeAddrR;
      end else begin
        avReaddata <= '0;
      end
    end
  end

  // Pin-group enables; all nine bits 8:0 are kept, group bits and the rest alike
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ioEnR <= `HPAG_RST_IO_ENABLE;
    end else if (avWrAcc && avAddress == `HPAG_OFS_IO_ENABLE) begin
      ioEnR <= (avWritedata[8:0] & avMask[8:0]) | (ioEnR & ~avMask[8:0]);
    end
  end

  // Direction bits, one per pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dirR <= `HPAG_RST_PIN_DIR;
    end else if (avWrAcc && avAddress == `HPAG_OFS_PIN_DIR) begin
      dirR <= (avWritedata[NPINS-1:0] & avMask[NPINS-1:0]) | (dirR & ~avMask[NPINS-1:0]);
    end
  end

  // Input bits track the pin, output bits hold the last write; no preload possible
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      datR <= '0;
    end else begin
      for (int i = 0; i < NPINS; i++) begin
        if (!dirR[i]) begin
          datR[i] <= pinSync[i];
        end else if (avWrAcc && avAddress == `HPAG_OFS_PIN_DATA && avMask[i]) begin
          datR[i] <= avWritedata[i];
        end
      end
    end
  end

  // Group enables spread over the pins
  always_comb begin
    ioEnPin = '0;
    for (int i = 0; i < 8; i++) begin
      ioEnPin[i]     = ioEnR[`HPAG_EN_LOWER_BYTE];
      ioEnPin[i + 8] = ioEnR[`HPAG_EN_UPPER_BYTE];
    end
    ioEnPin[`HPAG_PIN_CNTL_LO] = ioEnR[`HPAG_EN_ACCESS_CTRL];
    ioEnPin[`HPAG_PIN_CNTL_HI] = ioEnR[`HPAG_EN_ACCESS_CTRL];
    ioEnPin[`HPAG_PIN_STROBE]  = ioEnR[`HPAG_EN_ADDR_STROBE];
  end

  // Disabled port frees every pin; enabled port frees pins by their enables
  assign ioEnEff = hostPortEnable ? ioEnPin : '1;

  // Host logic sees fixed levels on pins taken for I/O
  assign hostPinView = (ioEnEff & `HPAG_FORCED_VIEW) | (~ioEnEff & pinSync);

  // Pin drive: I/O pins by direction, else data pins 0..15 by the host data path, control and strobe undriven
  always_comb begin
    pinOut_nxt = '0;
    pinOeN_nxt = '1;
    for (int i = 0; i < NPINS; i++) begin
      if (ioEnEff[i]) begin
        pinOut_nxt[i] = datR[i];
        pinOeN_nxt[i] = ~dirR[i];
      end else if (i < 16) begin
        pinOut_nxt[i] = hostDataOut[i % 16];
        pinOeN_nxt[i] = ~hostDataDrive;
      end
    end
  end

  // Registered pin outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinOut <= '0;
      pinOeN <= '1;
    end else begin
      pinOut <= pinOut_nxt;
      pinOeN <= pinOeN_nxt;
    end
  end

  // Host cycle decode; the read/write line gives the direction
  assign cycKind    = accKind(cycCntl);
  assign hostAddrWr = cycStart && cycKind == hpag_pkg::ACC_ADDR && !cycRead;
  assign hostCtrlWr = cycStart && cycKind == hpag_pkg::ACC_CTRL && !cycRead;
  assign dualMode   = ctrlR[`HPAG_CTRL_DUAL];
  assign addrSel    = ctrlR[`HPAG_CTRL_SEL];

  // Port control; host write wins over a same-cycle CPU write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlR <= '0;
    end else if (hostCtrlWr) begin
      ctrlR <= cycWdata;
    end else if (avWrAcc && avAddress == `HPAG_OFS_PORT_CTRL) begin
      ctrlR <= (avWritedata & avMask) | (ctrlR & ~avMask);
    end
  end

  // Pending increments; a new set wins over a same-cycle completion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      incRdPendR <= 1'b0;
      incWrPendR <= 1'b0;
    end else begin
      incRdPendR <= (cycStart && cycKind == hpag_pkg::ACC_DATA_INC && cycRead)
                    | (incRdPendR & ~memRdDone);
      incWrPendR <= (cycStart && cycKind == hpag_pkg::ACC_DATA_INC && !cycRead)
                    | (incWrPendR & ~memWrDone);
    end
  end

  // Increment only once the memory access that used the address is done
  assign rdIncNow = incRdPendR & memRdDone;
  assign wrIncNow = incWrPendR & memWrDone;

  // Read address register; an address write outranks an increment
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readAddrR <= `HPAG_RST_ADDR;
    end else if (hostAddrWr && (!dualMode || addrSel)) begin
      readAddrR <= cycWdata;
    end else if (rdIncNow || (!dualMode && wrIncNow)) begin
      readAddrR <= readAddrR + `HPAG_WORD_STEP;
    end
  end

  // Write address register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      writeAddrR <= `HPAG_RST_ADDR;
    end else if (hostAddrWr && (!dualMode || !addrSel)) begin
      writeAddrR <= cycWdata;
    end else if (wrIncNow || (!dualMode && rdIncNow)) begin
      writeAddrR <= writeAddrR + `HPAG_WORD_STEP;
    end
  end

  // Memory logic always uses fixed roles, independent of the select bit
  assign memReadAddr  = readAddrR;
  assign memWriteAddr = writeAddrR;

  // Host readback of control and address registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cycRdata <= '0;
    end else if (cycStart && cycRead) begin
      if (cycKind == hpag_pkg::ACC_CTRL) begin
        cycRdata <= ctrlR;
      end else if (cycKind == hpag_pkg::ACC_ADDR) begin
        cycRdata <= (!dualMode || addrSel) ? readAddrR : writeAddrR;
      end
    end
  end

  // Checks
  property p_disabledFree;
    @(posedge clk) disable iff (rst) !hostPortEnable |-> ioEnEff == '1;
  endproperty
  a_disabledFree: assert property (p_disabledFree) else $error("pins not freed");

  property p_forcedView;
    @(posedge clk) disable iff (rst)
      ioEnEff[`HPAG_PIN_STROBE] && ioEnEff[0] |->
        hostPinView[`HPAG_PIN_STROBE] && !hostPinView[0];
  endproperty
  a_forcedView: assert property (p_forcedView) else $error("forced view wrong");

  property p_outDrive;
    @(posedge clk) disable iff (rst)
      ioEnEff[`HPAG_PIN_STROBE] && dirR[`HPAG_PIN_STROBE] |=>
        !pinOeN[`HPAG_PIN_STROBE] && pinOut[`HPAG_PIN_STROBE] == $past(datR[`HPAG_PIN_STROBE]);
  endproperty
  a_outDrive: assert property (p_outDrive) else $error("output pin not driven");

  property p_inputTrack;
    @(posedge clk) disable iff (rst) !dirR[0] |=> datR[0] == $past(pinSync[0]);
  endproperty
  a_inputTrack: assert property (p_inputTrack) else $error("input data not sampled");

  property p_outWrite;
    @(posedge clk) disable iff (rst)
      avWrAcc && avAddress == `HPAG_OFS_PIN_DATA && dirR[0] && avByteenable[0] |=>
        datR[0] == $past(avWritedata[0]);
  endproperty
  a_outWrite: assert property (p_outWrite) else $error("output data write lost");

  property p_sharedLoad;
    @(posedge clk) disable iff (rst)
      hostAddrWr && !dualMode |=> readAddrR == $past(cycWdata) && writeAddrR == $past(cycWdata);
  endproperty
  a_sharedLoad: assert property (p_sharedLoad) else $error("shared load mismatch");

  property p_dualSelect;
    @(posedge clk) disable iff (rst)
      hostAddrWr && dualMode && addrSel && !wrIncNow |=>
        writeAddrR == $past(writeAddrR) && readAddrR == $past(cycWdata);
  endproperty
  a_dualSelect: assert property (p_dualSelect) else $error("select bit ignored");

  property p_readStep;
    @(posedge clk) disable iff (rst)
      rdIncNow && !hostAddrWr |=> readAddrR == $past(readAddrR) + `HPAG_WORD_STEP;
  endproperty
  a_readStep: assert property (p_readStep) else $error("read step not four");

  property p_dualOnlyMatch;
    @(posedge clk) disable iff (rst)
      dualMode && rdIncNow && !wrIncNow && !hostAddrWr |=> writeAddrR == $past(writeAddrR);
  endproperty
  a_dualOnlyMatch: assert property (p_dualOnlyMatch) else $error("wrong register stepped");

  property p_avAnswer;
    @(posedge clk) disable iff (rst) $rose(avRead) |-> avWaitrequest ##1 !avWaitrequest;
  endproperty
  a_avAnswer: assert property (p_avAnswer) else $error("bus answer late");

  c_sharedLoad: cover property (@(posedge clk) disable iff (rst) hostAddrWr && !dualMode);
  c_dualRdInc:  cover property (@(posedge clk) disable iff (rst) rdIncNow && dualMode);
  c_pinOutput:  cover property (@(posedge clk) disable iff (rst) !pinOeN[`HPAG_PIN_STROBE]);
  c_pinInput:   cover property (@(posedge clk) disable iff (rst) ioEnEff[0] && !dirR[0]);

endmodule

`default_nettype wire

// ---- logic/hpag_consts.svh ----
// Offsets, field positions, reset values and steps of the host port address and pin block
`ifndef HPAG_CONSTS_SVH
`define HPAG_CONSTS_SVH

// Register byte offsets on the Avalon slave
`define HPAG_OFS_IO_ENABLE   5'h00
`define HPAG_OFS_PIN_DIR     5'h04
`define HPAG_OFS_PIN_DATA    5'h08
`define HPAG_OFS_PORT_CTRL   5'h0C
`define HPAG_OFS_READ_ADDR   5'h10
`define HPAG_OFS_WRITE_ADDR  5'h14

// Pin-group enable bit positions in the I/O enable register
`define HPAG_EN_LOWER_BYTE   7
`define HPAG_EN_UPPER_BYTE   8
`define HPAG_EN_ACCESS_CTRL  1
`define HPAG_EN_ADDR_STROBE  2

// Pin index layout: data bus 0..15, access control 16..17, address strobe 18
`define HPAG_PIN_CNTL_LO     16
`define HPAG_PIN_CNTL_HI     17
`define HPAG_PIN_STROBE      18
`define HPAG_NUM_PINS        19

// Levels the host logic sees on a pin taken over for I/O
`define HPAG_FORCED_VIEW     19'h70000

// Port control register fields
`define HPAG_CTRL_DUAL       3
`define HPAG_CTRL_SEL        4

// Reset values
`define HPAG_RST_IO_ENABLE   9'h000
`define HPAG_RST_PIN_DIR     19'h00000
`define HPAG_RST_ADDR        32'h00000000

// Address step of one 32-bit word
`define HPAG_WORD_STEP       32'h00000004

`endif

// ---- logic/hpag_pkg.sv ----
// Types shared by the host port address and pin block
package hpag_pkg;

  // Access kinds selected by the access control pins
  typedef enum logic [1:0] {
    ACC_CTRL,
    ACC_DATA_INC,
    ACC_ADDR,
    ACC_DATA
  } hpag_acc_t;

endpackage

// ---- dv/hpag_host_model.sv ----
// Host processor model issuing decoded host cycles toward the address logic
`timescale 1ns/100ps
`default_nettype none

module hpag_host_model (
  // Clock
  input  wire logic   clk,
  // Decoded host cycle
  output logic        cycStart,
  output logic [1:0]  cycCntl,
  output logic        cycRead,
  output logic [31:0] cycWdata
);
  // Idle host: no cycle in flight
  initial begin
    cycStart = 1'b0;
    cycCntl  = 2'h0;
    cycRead  = 1'b0;
    cycWdata = 32'h00000000;
  end

  // One host cycle, held for exactly one sampling edge
  task automatic cycle(input logic [1:0] c, input logic r, input logic [31:0] d);
    @(posedge clk);
    cycStart <= 1'b1;
    cycCntl  <= c;
    cycRead  <= r;
    cycWdata <= (c == 2'h2) ? {d[31:2], 2'h0} : d;
    @(posedge clk);
    cycStart <= 1'b0;
    cycWdata <= ~d; // Released bus shows garbage, not the old word
  endtask
endmodule

`default_nettype wire

// ---- dv/host_port_address_and_gpio_tb.sv ----
// Self-checking bench for the host port address and pin block
`timescale 1ns/100ps
`default_nettype none
`include "hpag_consts.svh"

module host_port_address_and_gpio_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  avAddress = 5'h00;
  logic        avRead = 1'b0;
  logic        avWrite = 1'b0;
  logic [31:0] avWritedata = 32'h00000000;
  logic [31:0] avReaddata;
  logic        avWaitrequest;
  logic        hostPortEnable = 1'b0;
  logic        cycStart;
  logic [1:0]  cycCntl;
  logic        cycRead;
  logic [31:0] cycWdata;
  logic [31:0] cycRdata;
  logic        memRdDone = 1'b0;
  logic        memWrDone = 1'b0;
  logic [31:0] memReadAddr;
  logic [31:0] memWriteAddr;
  logic        hostDataDrive = 1'b0;
  logic [18:0] hostPinView;
  logic [18:0] pinIn = 19'h2A5A5;
  logic [18:0] pinOut;
  logic [18:0] pinOeN;
  logic [31:0] rd;
  logic [18:0] msk [4];
  int          pos [4];
  logic [4:0]  ofs [5];
  int          errors = 0;
  int          tests_run = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  hpag_core dut (
    .clk(clk), .rst(rst),
    .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
    .avByteenable(4'hF), .avWritedata(avWritedata),
    .avReaddata(avReaddata), .avWaitrequest(avWaitrequest),
    .hostPortEnable(hostPortEnable),
    .cycStart(cycStart), .cycCntl(cycCntl), .cycRead(cycRead),
    .cycWdata(cycWdata), .cycRdata(cycRdata),
    .memRdDone(memRdDone), .memWrDone(memWrDone),
    .memReadAddr(memReadAddr), .memWriteAddr(memWriteAddr),
    .hostDataOut(16'hC3C3), .hostDataDrive(hostDataDrive),
    .hostPinView(hostPinView),
    .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN)
  );

  hpag_host_model host (
    .clk(clk), .cycStart(cycStart), .cycCntl(cycCntl),
    .cycRead(cycRead), .cycWdata(cycWdata)
  );

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Avalon access; held until waitrequest is seen low at an edge
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avRead      <= ~w;
    avWrite     <= w;
    avAddress   <= a;
    avWritedata <= d;
    @(posedge clk);
    // Waitrequest seen as it stood at this edge; data is taken at the same edge
    while (avWaitrequest) @(posedge clk);
    rd = avReaddata;
    avRead  <= 1'b0;
    avWrite <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One memory completion pulse
  task automatic done(input logic w);
    @(posedge clk);
    memRdDone <= ~w;
    memWrDone <= w;
    @(posedge clk);
    memRdDone <= 1'b0;
    memWrDone <= 1'b0;
    tick(2);
  endtask

  task automatic hc(input logic [1:0] c, input logic r, input logic [31:0] d);
    host.cycle(c, r, d);
    tick(2);
  endtask

  task automatic chkA(input logic [31:0] r, input logic [31:0] w);
    chk("memReadAddr", memReadAddr, r);
    chk("memWriteAddr", memWriteAddr, w);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    results();
  end

  initial begin
    msk = '{19'h000FF, 19'h0FF00, 19'h30000, 19'h40000};
    pos = '{`HPAG_EN_LOWER_BYTE, `HPAG_EN_UPPER_BYTE, `HPAG_EN_ACCESS_CTRL, `HPAG_EN_ADDR_STROBE};
    ofs = '{`HPAG_OFS_IO_ENABLE, `HPAG_OFS_PIN_DIR, `HPAG_OFS_READ_ADDR,
            `HPAG_OFS_WRITE_ADDR, 5'h18};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    // Reset values, unmapped place included
    chk("pinOeN", pinOeN, 32'h0007FFFF);
    av(1'b1, 5'h18, 32'hFFFFFFFF);
    foreach (ofs[i]) begin
      av(1'b0, ofs[i], 32'h0);
      chk("regReset", rd, 32'h0);
    end
    // Port disabled: every pin free for I/O
    tick(4);
    chk("hostPinView", hostPinView, `HPAG_FORCED_VIEW);
    av(1'b1, `HPAG_OFS_PIN_DIR, 32'h00000001);
    tick(2);
    chk("pinOeN0", pinOeN[0], 32'h0);
    av(1'b1, `HPAG_OFS_PIN_DIR, 32'h0);
    @(posedge clk);
    hostPortEnable <= 1'b1;
    tick(5);
    chk("hostPinView", hostPinView, pinIn);
    // Each pin group taken over shows its fixed level to the host
    foreach (pos[i]) begin
      av(1'b1, `HPAG_OFS_IO_ENABLE, 32'h1 << pos[i]);
      tick(2);
      chk("hostPinView", hostPinView, (pinIn & ~msk[i]) | (`HPAG_FORCED_VIEW & msk[i]));
    end
    av(1'b0, `HPAG_OFS_IO_ENABLE, 32'h0);
    chk("ioEnable", rd, 32'h00000004);
    chk("strobeView", hostPinView[18], 32'h1);
    // Host function still drives data pins not taken over
    @(posedge clk);
    hostDataDrive <= 1'b1;
    tick(2);
    chk("pinOeNData", pinOeN[15:0], 32'h0);
    chk("pinOutData", pinOut[15:0], 32'h0000C3C3);
    @(posedge clk);
    hostDataDrive <= 1'b0;
    // Strobe pin as input, then output
    pinIn <= 19'h6A5A5;
    tick(5);
    av(1'b1, `HPAG_OFS_PIN_DATA, 32'h0);
    av(1'b0, `HPAG_OFS_PIN_DATA, 32'h0);
    chk("pinData18", rd & 32'h00040000, 32'h00040000);
    av(1'b1, `HPAG_OFS_PIN_DIR, 32'h00040001);
    tick(2);
    chk("pinOeN18", pinOeN[18], 32'h0);
    chk("pinOut18", pinOut[18], 32'h1);
    av(1'b1, `HPAG_OFS_PIN_DATA, 32'h0);
    tick(2);
    chk("pinOut18", pinOut[18], 32'h0);
    av(1'b0, `HPAG_OFS_PIN_DATA, 32'h0);
    chk("pinData18", rd & 32'h00040000, 32'h0);
    chk("pinData0", rd & 32'h00000001, 32'h0);
    // Shared mode: one address seen by both paths
    hc(hpag_pkg::ACC_CTRL, 1'b0, 32'h0);
    hc(hpag_pkg::ACC_ADDR, 1'b0, 32'h100);
    chkA(32'h100, 32'h100);
    hc(hpag_pkg::ACC_DATA_INC, 1'b1, 32'h0);
    chkA(32'h100, 32'h100);
    done(1'b0);
    chkA(32'h104, 32'h104);
    hc(hpag_pkg::ACC_ADDR, 1'b1, 32'h0);
    chk("cycRdata", cycRdata, 32'h104);
    hc(hpag_pkg::ACC_DATA, 1'b1, 32'h0);
    done(1'b0);
    chkA(32'h104, 32'h104);
    hc(hpag_pkg::ACC_ADDR, 1'b0, 32'h200);
    hc(hpag_pkg::ACC_DATA_INC, 1'b0, 32'h0);
    done(1'b1);
    chkA(32'h204, 32'h204);
    // Dual mode: select steers host accesses only
    hc(hpag_pkg::ACC_CTRL, 1'b0, 32'h18);
    hc(hpag_pkg::ACC_ADDR, 1'b0, 32'h300);
    chkA(32'h300, 32'h204);
    hc(hpag_pkg::ACC_CTRL, 1'b0, 32'h08);
    hc(hpag_pkg::ACC_ADDR, 1'b0, 32'h400);
    chkA(32'h300, 32'h400);
    av(1'b0, `HPAG_OFS_READ_ADDR, 32'h0);
    chk("readAddrReg", rd, 32'h300);
    av(1'b0, `HPAG_OFS_WRITE_ADDR, 32'h0);
    chk("writeAddrReg", rd, 32'h400);
    hc(hpag_pkg::ACC_DATA_INC, 1'b1, 32'h0);
    chkA(32'h300, 32'h400);
    done(1'b0);
    chkA(32'h304, 32'h400);
    hc(hpag_pkg::ACC_DATA_INC, 1'b0, 32'h0);
    done(1'b1);
    chkA(32'h304, 32'h404);
    hc(hpag_pkg::ACC_ADDR, 1'b1, 32'h0);
    chk("cycRdata", cycRdata, 32'h404);
    // Control readback by the host and by the CPU
    hc(hpag_pkg::ACC_CTRL, 1'b1, 32'h0);
    chk("ctrlHostRead", cycRdata, 32'h00000008);
    av(1'b0, `HPAG_OFS_PORT_CTRL, 32'h0);
    chk("ctrlCpuRead", rd, 32'h00000008);
    results();
  end
endmodule

`default_nettype wire
